//--- rtl/cpp_params.svh
// Constants for the charger power path register bank
`ifndef CPP_PARAMS_SVH
`define CPP_PARAMS_SVH
// Register offsets
`define CPP_ADDR_PPATH 8'h01
`define CPP_ADDR_INT 8'h02
`define CPP_ADDR_CHGSTAT 8'h03
`define CPP_ADDR_TCFG 8'h04
// Power path control field positions
`define CPP_PP_USB_PRES 7
`define CPP_PP_AC_PRES 6
`define CPP_PP_USB_DIS 5
`define CPP_PP_AC_DIS 4
// Interrupt register field positions
`define CPP_INT_MASK_HI 7
`define CPP_INT_MASK_LO 5
`define CPP_INT_FLAG_HI 3
`define CPP_INT_FLAG_LO 0
`define CPP_FLAG_TOUCH 3
`define CPP_FLAG_BUTTON 2
`define CPP_FLAG_APPLIED 1
`define CPP_FLAG_REMOVED 0
`define CPP_MASK_INPUT 2
`define CPP_MASK_TOUCH 1
`define CPP_MASK_BUTTON 0
// Timer config field positions
`define CPP_TCFG_TIME_HI 7
`define CPP_TCFG_TIME_LO 6
`define CPP_TCFG_TMR_EN 5
// Reset values
`define CPP_RST_AC_ILIM 2'h3
`define CPP_RST_USB_ILIM 2'h1
`define CPP_RST_MASK 3'h0
`define CPP_RST_FLAG 4'h0
`define CPP_RST_TCFG 8'h31
`define CPP_RD_ZERO 8'h00
`endif

//--- rtl/cpp_pkg.sv
// Types shared by the charger power path register bank
package cpp_pkg;
	// Whole module state, registered as one word
	typedef struct packed {
		logic [11:0] sync1;
		logic [11:0] sync2;
		logic [3:0] prev;
		logic usb_dis;
		logic ac_dis;
		logic [1:0] ac_ilim;
		logic [1:0] usb_ilim;
		logic [2:0] mask;
		logic [3:0] flag;
		logic [7:0] tcfg;
		logic [7:0] rdata;
		logic int_n;
		logic clr_tmr;
	} cpp_state_s;
endpackage : cpp_pkg

//--- rtl/cpp_regs.sv
// Charger power path control, interrupt and charger status registers
`timescale 1ns/10ps
`include "cpp_params.svh"

module cpp_regs
#(
	parameter bit PB_ACTIVE_HIGH = 1'b0
)
(
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	input wire logic USB_VALID,
	input wire logic AC_VALID,
	input wire logic TOUCH_DET,
	input wire logic PUSH_BUTTON_INPUT,
	input wire logic THERM_REG,
	input wire logic LOAD_SHARE,
	input wire logic TEMP_SUSPEND,
	input wire logic TERM_DONE,
	input wire logic FAST_TIMEOUT,
	input wire logic PRE_TIMEOUT,
	input wire logic NO_SENSOR,
	input wire logic UNDERVOLTAGE_LOCKOUT,
	output logic INT_N,
	output logic USB_SUSPEND,
	output logic AC_DISABLE,
	output logic [1:0] AC_ILIM,
	output logic [1:0] USB_ILIM,
	output logic CLEAR_TIMERS,
	output logic [1:0] SAFETY_TIME_SEL,
	output logic SAFETY_TIMER_EN,
	output logic [4:0] CHG_CTRL
);

	// Indices into the synchroniser vector
	localparam int I_USB = 0;
	localparam int I_AC = 1;
	localparam int I_TOUCH = 2;
	localparam int I_PB = 3;
	localparam int I_THERM = 4;
	localparam int I_LOAD = 5;
	localparam int I_TSUSP = 6;
	localparam int I_TERM = 7;
	localparam int I_FAST = 8;
	localparam int I_PRE = 9;
	localparam int I_NOSNS = 10;
	localparam int I_LOCK = 11;
	// Synchronisers reset to the pin idle levels, so no false button edge follows reset
	localparam logic [11:0] SYNC_IDLE = PB_ACTIVE_HIGH ? 12'h000 : (12'h001 << I_PB);

	cpp_pkg::cpp_state_s s_q;
	cpp_pkg::cpp_state_s s_d;
	logic [11:0] raw;
	logic usb_on;
	logic usb_off;
	logic ac_on;
	logic ac_off;
	logic pb_act;
	logic [3:0] ev;
	logic lockout;
	logic rd_int;
	logic [7:0] chg_stat;

	// True for the four mapped offsets
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == `CPP_ADDR_PPATH) || (a == `CPP_ADDR_INT)
			|| (a == `CPP_ADDR_CHGSTAT) || (a == `CPP_ADDR_TCFG);
	endfunction : is_mapped

	// Gather pin inputs for the two-stage synchroniser
	assign raw = {UNDERVOLTAGE_LOCKOUT, NO_SENSOR, PRE_TIMEOUT,
		FAST_TIMEOUT, TERM_DONE, TEMP_SUSPEND, LOAD_SHARE, THERM_REG,
		PUSH_BUTTON_INPUT, TOUCH_DET, AC_VALID, USB_VALID};

	// Edge detection on synchronised inputs
	assign pb_act = PB_ACTIVE_HIGH ? s_q.sync2[I_PB] : ~s_q.sync2[I_PB];
	assign usb_on = s_q.sync2[I_USB] & ~s_q.prev[0];
	assign usb_off = ~s_q.sync2[I_USB] & s_q.prev[0];
	assign ac_on = s_q.sync2[I_AC] & ~s_q.prev[1];
	assign ac_off = ~s_q.sync2[I_AC] & s_q.prev[1];
	assign lockout = s_q.sync2[I_LOCK];
	assign rd_int = REG_RD && (REG_ADDR == `CPP_ADDR_INT);

	// Event vector in flag bit order
	always_comb
	begin
		ev = 4'h0;
		ev[`CPP_FLAG_TOUCH] = s_q.sync2[I_TOUCH] & ~s_q.prev[2];
		ev[`CPP_FLAG_BUTTON] = pb_act & ~s_q.prev[3];
		ev[`CPP_FLAG_APPLIED] = usb_on | ac_on;
		ev[`CPP_FLAG_REMOVED] = usb_off | ac_off;
	end

	// Live charger status word
	always_comb
	begin
		chg_stat = 8'h00;
		chg_stat[7] = s_q.sync2[I_THERM];
		chg_stat[6] = s_q.sync2[I_LOAD];
		chg_stat[5] = s_q.sync2[I_TSUSP];
		chg_stat[4] = s_q.sync2[I_TERM]
			& (s_q.sync2[I_USB] | s_q.sync2[I_AC]);
		chg_stat[2] = s_q.sync2[I_FAST];
		chg_stat[1] = s_q.sync2[I_PRE];
		chg_stat[0] = s_q.sync2[I_NOSNS];
	end

	// Next state of the whole bank
	always_comb
	begin
		s_d = s_q;
		s_d.sync1 = raw;
		s_d.sync2 = s_q.sync1;
		s_d.prev = {pb_act, s_q.sync2[I_TOUCH], s_q.sync2[I_AC],
			s_q.sync2[I_USB]};
		// Host writes touch only the writable fields
		if (REG_WR)
		begin
			case (REG_ADDR)
				`CPP_ADDR_PPATH:
				begin
					s_d.usb_dis = REG_WDATA[`CPP_PP_USB_DIS];
					s_d.ac_dis = REG_WDATA[`CPP_PP_AC_DIS];
					s_d.ac_ilim = REG_WDATA[3:2];
					s_d.usb_ilim = REG_WDATA[1:0];
				end
				`CPP_ADDR_INT:
				begin
					s_d.mask = REG_WDATA[`CPP_INT_MASK_HI:`CPP_INT_MASK_LO];
				end
				`CPP_ADDR_TCFG:
				begin
					s_d.tcfg = REG_WDATA;
				end
				default:
				begin
					s_d.tcfg = s_q.tcfg;
				end
			endcase
		end
		// Own input removal restores its limit field
		if (usb_off)
		begin
			s_d.usb_ilim = `CPP_RST_USB_ILIM;
		end
		if (ac_off)
		begin
			s_d.ac_ilim = `CPP_RST_AC_ILIM;
		end
		// A read clears flags, a new event in the same cycle wins
		if (rd_int)
		begin
			s_d.flag = ev;
		end
		else
		begin
			s_d.flag = s_q.flag | ev;
		end
		// Read data captured at the read
		if (REG_RD)
		begin
			case (REG_ADDR)
				`CPP_ADDR_PPATH:
				begin
					s_d.rdata = {s_q.sync2[I_USB], s_q.sync2[I_AC], s_q.usb_dis,
						s_q.ac_dis, s_q.ac_ilim, s_q.usb_ilim};
				end
				`CPP_ADDR_INT:
				begin
					s_d.rdata = {s_q.mask, 1'b0, s_q.flag};
				end
				`CPP_ADDR_CHGSTAT:
				begin
					s_d.rdata = chg_stat;
				end
				`CPP_ADDR_TCFG:
				begin
					s_d.rdata = s_q.tcfg;
				end
				default:
				begin
					s_d.rdata = `CPP_RD_ZERO;
				end
			endcase
		end
		// Interrupt pin low while any enabled flag stands
		s_d.int_n = ~((s_q.mask[`CPP_MASK_INPUT]
			& (s_q.flag[`CPP_FLAG_APPLIED] | s_q.flag[`CPP_FLAG_REMOVED]))
			| (s_q.mask[`CPP_MASK_TOUCH] & s_q.flag[`CPP_FLAG_TOUCH])
			| (s_q.mask[`CPP_MASK_BUTTON] & s_q.flag[`CPP_FLAG_BUTTON]));
		// Timers cleared while both inputs are absent
		s_d.clr_tmr = ~s_q.sync2[I_USB] & ~s_q.sync2[I_AC];
		// Lockout reloads the control, limit, mask, flag and timer config defaults but keeps sampling
		if (lockout)
		begin
			s_d.usb_dis = 1'b0;
			s_d.ac_dis = 1'b0;
			s_d.ac_ilim = `CPP_RST_AC_ILIM;
			s_d.usb_ilim = `CPP_RST_USB_ILIM;
			s_d.mask = `CPP_RST_MASK;
			s_d.flag = `CPP_RST_FLAG;
			s_d.tcfg = `CPP_RST_TCFG;
		end
	end

	// State register with synchronous reset
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			s_q.sync1 <= SYNC_IDLE;
			s_q.sync2 <= SYNC_IDLE;
			s_q.prev <= 4'h0;
			s_q.usb_dis <= 1'b0;
			s_q.ac_dis <= 1'b0;
			s_q.ac_ilim <= `CPP_RST_AC_ILIM;
			s_q.usb_ilim <= `CPP_RST_USB_ILIM;
			s_q.mask <= `CPP_RST_MASK;
			s_q.flag <= `CPP_RST_FLAG;
			s_q.tcfg <= `CPP_RST_TCFG;
			s_q.rdata <= `CPP_RD_ZERO;
			s_q.int_n <= 1'b1;
			s_q.clr_tmr <= 1'b1;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// Outputs straight from state flops
	assign REG_RDATA = s_q.rdata;
	assign INT_N = s_q.int_n;
	assign USB_SUSPEND = s_q.usb_dis;
	assign AC_DISABLE = s_q.ac_dis;
	assign AC_ILIM = s_q.ac_ilim;
	assign USB_ILIM = s_q.usb_ilim;
	assign CLEAR_TIMERS = s_q.clr_tmr;
	assign SAFETY_TIME_SEL = s_q.tcfg[`CPP_TCFG_TIME_HI:`CPP_TCFG_TIME_LO];
	assign SAFETY_TIMER_EN = s_q.tcfg[`CPP_TCFG_TMR_EN];
	assign CHG_CTRL = s_q.tcfg[4:0];

	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (RST);

	// Enabled input flag pulls the pin low
	a_input_int_low:
	assert property (s_q.mask[`CPP_MASK_INPUT] && (s_q.flag[1:0] != 2'h0) |=> !INT_N)
	else $error("Input change flag did not pull pin low");

	// Pin released when no enabled flag stands
	a_int_release_high:
	assert property ((s_q.mask & {|s_q.flag[1:0], s_q.flag[3], s_q.flag[2]}) == 3'h0
		|=> INT_N)
	else $error("Pin held low without enabled flag");

	// Button flag drives pin only when enabled
	a_button_int_gate:
	assert property (!s_q.mask[`CPP_MASK_BUTTON] && s_q.flag[2] && s_q.flag[3:0] == 4'h4
		|=> INT_N)
	else $error("Disabled button flag drove pin");

	// Touch edge sets its flag
	a_touch_sets_flag:
	assert property (ev[`CPP_FLAG_TOUCH] && !lockout |=> s_q.flag[`CPP_FLAG_TOUCH])
	else $error("Touch event lost");

	// Quiet read clears all flags
	a_read_clears_flags:
	assert property (rd_int && ev == 4'h0 && !lockout |=> s_q.flag == 4'h0)
	else $error("Read did not clear flags");

	// Writes never change flags
	a_write_keeps_flags:
	assert property (REG_WR && !rd_int && !lockout
		|=> s_q.flag == ($past(s_q.flag) | $past(ev)))
	else $error("Write altered event flags");

	// USB removal restores its current limit
	a_usb_limit_restore:
	assert property (usb_off |=> USB_ILIM == `CPP_RST_USB_ILIM)
	else $error("USB limit not restored on removal");

	// Unmapped reads return zero one edge on
	a_unmapped_reads_zero:
	assert property (REG_RD && !is_mapped(REG_ADDR) |=> REG_RDATA == `CPP_RD_ZERO)
	else $error("Unmapped read not zero");

	// Both inputs absent clears timers
	a_timer_clear_both:
	assert property (!s_q.sync2[I_USB] && !s_q.sync2[I_AC] |=> CLEAR_TIMERS)
	else $error("Timers not cleared with no input");

	// Lockout reloads timer configuration
	a_lockout_reload_cfg:
	assert property (lockout |=> s_q.tcfg == `CPP_RST_TCFG)
	else $error("Lockout did not reload timer config");

	// Write sets the USB suspend output
	a_usb_suspend_write:
	assert property (REG_WR && REG_ADDR == `CPP_ADDR_PPATH && !lockout
		|=> USB_SUSPEND == $past(REG_WDATA[`CPP_PP_USB_DIS]))
	else $error("USB disable bit not applied");

	// Write sets the adapter disable output
	a_ac_disable_write:
	assert property (REG_WR && REG_ADDR == `CPP_ADDR_PPATH && !lockout
		|=> AC_DISABLE == $past(REG_WDATA[`CPP_PP_AC_DIS]))
	else $error("Adapter disable bit not applied");

	// Write sets the adapter limit unless the adapter just went away
	a_ac_limit_write:
	assert property (REG_WR && REG_ADDR == `CPP_ADDR_PPATH && !ac_off && !lockout
		|=> AC_ILIM == $past(REG_WDATA[3:2]))
	else $error("Adapter limit not applied");

	// Write sets the USB limit unless USB just went away
	a_usb_limit_write:
	assert property (REG_WR && REG_ADDR == `CPP_ADDR_PPATH && !usb_off && !lockout
		|=> USB_ILIM == $past(REG_WDATA[1:0]))
	else $error("USB limit not applied");

	// Adapter removal restores its current limit
	a_ac_limit_restore:
	assert property (ac_off |=> AC_ILIM == `CPP_RST_AC_ILIM)
	else $error("Adapter limit not restored on removal");

	// Button edge sets its flag
	a_button_sets_flag:
	assert property (ev[`CPP_FLAG_BUTTON] && !lockout |=> s_q.flag[`CPP_FLAG_BUTTON])
	else $error("Button event lost");

	// Input removal sets its flag
	a_removed_sets_flag:
	assert property (ev[`CPP_FLAG_REMOVED] && !lockout |=> s_q.flag[`CPP_FLAG_REMOVED])
	else $error("Input removal event lost");

	// Enabled touch flag pulls the pin low
	a_touch_int_low:
	assert property (s_q.mask[`CPP_MASK_TOUCH] && s_q.flag[`CPP_FLAG_TOUCH] |=> !INT_N)
	else $error("Touch flag did not pull pin low");

	// Timer config write reaches the timer outputs
	a_timer_cfg_write:
	assert property (REG_WR && REG_ADDR == `CPP_ADDR_TCFG && !lockout
		|=> {SAFETY_TIME_SEL, SAFETY_TIMER_EN} == $past(REG_WDATA[7:5]))
	else $error("Timer config write not applied");

endmodule : cpp_regs

//--- testbench/cpp_host.sv
// Host model that drives the register strobe port
`timescale 1ns/10ps
module cpp_host
(
	input wire logic REF_CLK,
	output logic [7:0] REG_ADDR,
	output logic REG_WR,
	output logic [7:0] REG_WDATA,
	output logic REG_RD,
	input wire logic [7:0] REG_RDATA
);
	// Bus idles with both strobes low
	initial
	begin
		REG_ADDR = 8'h00;
		REG_WR = 1'b0;
		REG_WDATA = 8'h00;
		REG_RD = 1'b0;
	end
	// Single byte write, one cycle strobe; flags are never targeted as data
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge REF_CLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge REF_CLK);
		REG_WR <= 1'b0;
		REG_WDATA <= ~d; // Stale data must not look valid
	endtask : wr
	// Single byte read; data is taken at the next edge, while it still holds
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge REF_CLK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge REF_CLK);
		REG_RD <= 1'b0;
		@(posedge REF_CLK);
		d = REG_RDATA;
	endtask : rd
endmodule : cpp_host

//--- testbench/cpp_regs_tb_top.sv
// Self-checking bench for the charger power path register bank
`timescale 1ns/10ps
module cpp_regs_tb_top;
	typedef struct packed {logic [7:0] wa; logic [7:0] wd; logic [7:0] ra; logic [7:0] ex;} cpp_row_s;
	// Write address and data, then read address and expected byte
	localparam cpp_row_s ROWS [0:16] = '{32'h05ff010d, 32'h05ff0200, 32'h05ff0431, 32'h013a013a,
		32'h01350135, 32'h010f010f, 32'h01c00100, 32'h04000400, 32'h045f045f, 32'h04af04af,
		32'h04ff04ff, 32'h02ff02e0, 32'h02000200, 32'h03ff0300, 32'h05ff0500, 32'h00ff0000, 32'hffffff00};
	logic REF_CLK = 1'b0;
	logic RST = 1'b1;
	logic USB_VALID = 1'b0;
	logic AC_VALID = 1'b0;
	logic TOUCH_DET = 1'b0;
	logic PUSH_BUTTON_INPUT = 1'b1;
	logic UNDERVOLTAGE_LOCKOUT = 1'b0;
	logic [6:0] st = 7'h00;
	logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
	logic REG_WR, REG_RD, INT_N, USB_SUSPEND, AC_DISABLE, CLEAR_TIMERS, SAFETY_TIMER_EN;
	logic [1:0] AC_ILIM, USB_ILIM, SAFETY_TIME_SEL;
	logic [4:0] CHG_CTRL;
	int err_total = 0;
	int total_checks = 0;
	// Free running clock, 50 ns period
	always #25 REF_CLK = ~REF_CLK;
	cpp_host cpp_host_i (.REF_CLK(REF_CLK), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA),
		.REG_RD(REG_RD), .REG_RDATA(REG_RDATA));
	cpp_regs #(.PB_ACTIVE_HIGH(1'b0)) cpp_regs_i (.REF_CLK(REF_CLK), .RST(RST), .REG_ADDR(REG_ADDR),
		.REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
		.USB_VALID(USB_VALID), .AC_VALID(AC_VALID), .TOUCH_DET(TOUCH_DET), .PUSH_BUTTON_INPUT(PUSH_BUTTON_INPUT),
		.THERM_REG(st[6]), .LOAD_SHARE(st[5]), .TEMP_SUSPEND(st[4]), .TERM_DONE(st[3]), .FAST_TIMEOUT(st[2]),
		.PRE_TIMEOUT(st[1]), .NO_SENSOR(st[0]), .UNDERVOLTAGE_LOCKOUT(UNDERVOLTAGE_LOCKOUT), .INT_N(INT_N),
		.USB_SUSPEND(USB_SUSPEND), .AC_DISABLE(AC_DISABLE), .AC_ILIM(AC_ILIM), .USB_ILIM(USB_ILIM),
		.CLEAR_TIMERS(CLEAR_TIMERS), .SAFETY_TIME_SEL(SAFETY_TIME_SEL), .SAFETY_TIMER_EN(SAFETY_TIMER_EN),
		.CHG_CTRL(CHG_CTRL));
	// Compare seen against expected and count
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// Read one register and compare
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		cpp_host_i.rd(a, d);
		chk(d, e);
	endtask : rc
	// Bounded wait for the interrupt pin level, sampled between edges
	task automatic wint(input logic lvl);
		for (int i = 0; i < 8 && INT_N !== lvl; i++)
			@(negedge REF_CLK);
		chk({7'h00, INT_N}, {7'h00, lvl});
		if (INT_N !== lvl)
			end_of_test();
	endtask : wint
	// Verdict and end of run
	task automatic end_of_test;
		$display("checks=%0d errors=%0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	// Hang guard
	initial
	begin
		#1000000;
		err_total++;
		end_of_test();
	end
	// Main sequence
	initial
	begin
		repeat (3) @(posedge REF_CLK);
		RST <= 1'b0;
		@(posedge REF_CLK);
		chk({7'h00, CLEAR_TIMERS}, 8'h01);
		foreach (ROWS[i])
		begin
			cpp_host_i.wr(ROWS[i].wa, ROWS[i].wd);
			rc(ROWS[i].ra, ROWS[i].ex);
			if (ROWS[i].ra == 8'h01)
				chk({2'h0, USB_SUSPEND, AC_DISABLE, AC_ILIM, USB_ILIM}, ROWS[i].ex & 8'h3f);
			if (ROWS[i].ra == 8'h04)
				chk({SAFETY_TIME_SEL, SAFETY_TIMER_EN, CHG_CTRL}, ROWS[i].ex);
		end
		chk({7'h00, INT_N}, 8'h01);
		$display("register rows done");
		// Input applied and removed with the input change enable set
		cpp_host_i.wr(8'h02, 8'h80);
		USB_VALID <= 1'b1;
		wint(1'b0);
		rc(8'h01, 8'h80);
		chk({7'h00, CLEAR_TIMERS}, 8'h00);
		rc(8'h02, 8'h82);
		wint(1'b1);
		rc(8'h02, 8'h80);
		cpp_host_i.wr(8'h01, 8'h0f);
		USB_VALID <= 1'b0;
		wint(1'b0);
		rc(8'h01, 8'h0d);
		rc(8'h02, 8'h81);
		chk({7'h00, CLEAR_TIMERS}, 8'h01);
		// Adapter applied with every enable clear
		cpp_host_i.wr(8'h02, 8'h00);
		AC_VALID <= 1'b1;
		repeat (6) @(posedge REF_CLK);
		chk({7'h00, INT_N}, 8'h01);
		rc(8'h01, 8'h4d);
		rc(8'h02, 8'h02);
		$display("input events done");
		// Touch then push button
		cpp_host_i.wr(8'h02, 8'h40);
		TOUCH_DET <= 1'b1;
		wint(1'b0);
		rc(8'h02, 8'h48);
		rc(8'h02, 8'h40);
		cpp_host_i.wr(8'h02, 8'h20);
		PUSH_BUTTON_INPUT <= 1'b0;
		wint(1'b0);
		rc(8'h02, 8'h24);
		$display("touch and button done");
		// Live charger status, termination needs an input
		st <= 7'h7f;
		repeat (5) @(posedge REF_CLK);
		rc(8'h03, 8'hf7);
		AC_VALID <= 1'b0;
		repeat (5) @(posedge REF_CLK);
		rc(8'h03, 8'he7);
		$display("status done");
		// Lockout restores defaults
		cpp_host_i.wr(8'h01, 8'h30);
		UNDERVOLTAGE_LOCKOUT <= 1'b1;
		repeat (5) @(posedge REF_CLK);
		UNDERVOLTAGE_LOCKOUT <= 1'b0;
		repeat (4) @(posedge REF_CLK);
		rc(8'h01, 8'h0d);
		rc(8'h04, 8'h31);
		rc(8'h02, 8'h00);
		$display("lockout done");
		end_of_test();
	end
endmodule : cpp_regs_tb_top
